// ---- hw/arb_consts.svh ----
// offsets, field positions, reset values and counts of the result bank
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH
`define ARB_OFS_DSCHG  8'h14
`define ARB_BIT_DSCHG  5
`define ARB_OFS_CTRL   8'h2e
`define ARB_RST_CTRL   8'h30
`define ARB_BIT_EN     7
`define ARB_BIT_RATE   6
`define ARB_OFS_DIS0   8'h2f
`define ARB_OFS_DIS1   8'h30
`define ARB_MSK_DIS0   8'hfe
`define ARB_MSK_DIS1   8'h30
`define ARB_OFS_IN_CUR 8'h31
`define ARB_OFS_BT_CUR 8'h33
`define ARB_OFS_BUS_V  8'h35
`define ARB_OFS_AD1_V  8'h37
`define ARB_OFS_AD2_V  8'h39
`define ARB_OFS_BAT_V  8'h3b
`define ARB_OFS_SYS_V  8'h3d
`define ARB_OFS_THERM  8'h3f
`define ARB_OFS_DIE_T  8'h41
`define ARB_RST_RES    16'h0000
`define ARB_NUM_CH     9
`define ARB_BITS_BYTE  4'h8
`endif

// ---- hw/arb_pkg.sv ----
// types shared by the result bank and its serial port
package arb_pkg;
  typedef logic [15:0] arb_word_t;
  typedef logic [3:0]  arb_chan_t;
  typedef enum {ARB_S_IDLE, ARB_S_PICK, ARB_S_WAIT} arb_seq_t;
  typedef enum {ARB_I_IDLE, ARB_I_ADDR, ARB_I_AACK, ARB_I_WDATA,
                ARB_I_WACK, ARB_I_RDATA, ARB_I_RACK} arb_i2c_t;
endpackage

// ---- hw/arb_i2c.sv ----
// two-wire serial target, byte level
`include "arb_consts.svh"
module arb_i2c (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [6:0] i_dev_addr,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_start,
  output logic            o_wbyte_vld,
  output logic [7:0]      o_wbyte,
  output logic            o_rd_take,
  input  wire logic [7:0] i_rd_byte
);
  arb_pkg::arb_i2c_t st_q;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic       rw_q;
  logic       nack_q;
  logic       oe_q;
  wire rise = i_scl & ~scl_q;
  wire fall = ~i_scl & scl_q;
  wire stop = scl_q & i_scl & ~sda_q & i_sda;
  assign o_start     = scl_q & i_scl & sda_q & ~i_sda;
  assign o_sda_out   = 1'b0;
  assign o_sda_oe    = oe_q;
  assign o_wbyte     = sr_q;
  assign o_wbyte_vld = fall && st_q == arb_pkg::ARB_I_WDATA && cnt_q == `ARB_BITS_BYTE;
  assign o_rd_take   = fall && ((st_q == arb_pkg::ARB_I_AACK && rw_q) ||
                                (st_q == arb_pkg::ARB_I_RACK && !nack_q));

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q   <= arb_pkg::ARB_I_IDLE;
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      cnt_q  <= 4'h0;
      sr_q   <= 8'h00;
      tx_q   <= 8'h00;
      rw_q   <= 1'b0;
      nack_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      if (o_start) begin
        st_q  <= arb_pkg::ARB_I_ADDR;
        cnt_q <= 4'h0;
        oe_q  <= 1'b0;
      end else if (stop) begin
        st_q <= arb_pkg::ARB_I_IDLE;
        oe_q <= 1'b0;
      end else if (rise) begin
        if (st_q == arb_pkg::ARB_I_ADDR || st_q == arb_pkg::ARB_I_WDATA) begin
          sr_q  <= {sr_q[6:0], i_sda};
          cnt_q <= cnt_q + 4'h1;
        end
        if (st_q == arb_pkg::ARB_I_RACK) nack_q <= i_sda;
      end else if (fall) begin
        case (st_q)
          arb_pkg::ARB_I_ADDR: begin
            if (cnt_q == `ARB_BITS_BYTE) begin
              st_q <= (sr_q[7:1] == i_dev_addr) ? arb_pkg::ARB_I_AACK : arb_pkg::ARB_I_IDLE;
              oe_q <= (sr_q[7:1] == i_dev_addr);
              rw_q <= sr_q[0];
            end
          end
          arb_pkg::ARB_I_AACK, arb_pkg::ARB_I_RACK: begin
            cnt_q <= 4'h0;
            if (o_rd_take) begin
              tx_q <= i_rd_byte;
              oe_q <= ~i_rd_byte[7];
              st_q <= arb_pkg::ARB_I_RDATA;
            end else begin
              oe_q <= 1'b0;
              st_q <= (st_q == arb_pkg::ARB_I_AACK) ? arb_pkg::ARB_I_WDATA : arb_pkg::ARB_I_IDLE;
            end
          end
          arb_pkg::ARB_I_WDATA: begin
            if (cnt_q == `ARB_BITS_BYTE) begin
              oe_q <= 1'b1;
              st_q <= arb_pkg::ARB_I_WACK;
            end
          end
          arb_pkg::ARB_I_WACK: begin
            oe_q  <= 1'b0;
            cnt_q <= 4'h0;
            st_q  <= arb_pkg::ARB_I_WDATA;
          end
          arb_pkg::ARB_I_RDATA: begin
            if (cnt_q == `ARB_BITS_BYTE - 4'h1) begin
              oe_q   <= 1'b0;
              nack_q <= 1'b0;
              st_q   <= arb_pkg::ARB_I_RACK;
            end else begin
              tx_q  <= {tx_q[6:0], 1'b0};
              oe_q  <= ~tx_q[6];
              cnt_q <= cnt_q + 4'h1;
            end
          end
          default: st_q <= arb_pkg::ARB_I_IDLE;
        endcase
      end
    end
  end
endmodule // arb_i2c

// ---- hw/arb_bank.sv ----
// measurement result bank with converter sequencing and serial access
`include "arb_consts.svh"
module arb_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h50, // arbitrary value
  parameter int         NUM_CH   = `ARB_NUM_CH
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_reg_rst,
  input  wire logic                i_wdog_expire,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda_out,
  output logic                     o_sda_oe,
  output logic                     o_conv_req,
  output arb_pkg::arb_chan_t       o_conv_chan,
  output logic                     o_conv_busy,
  input  wire logic                i_conv_done,
  input  wire arb_pkg::arb_word_t  i_conv_data
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (NUM_CH != `ARB_NUM_CH) begin : g_bad_ch
    $error("channel count must match the register map");
  end

  localparam arb_pkg::arb_chan_t CH_IN_CUR = 4'h0;
  localparam arb_pkg::arb_chan_t CH_BT_CUR = 4'h1;
  localparam arb_pkg::arb_chan_t CH_END    = 4'(NUM_CH);
  localparam arb_pkg::arb_chan_t CH_NONE   = 4'hf;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // result index for an address, either byte of the pair
  function automatic arb_pkg::arb_chan_t res_index(input logic [7:0] a);
    logic [7:0] base;
    base = {a[7:1], 1'b1};
    if (a == {a[7:1], 1'b0}) base = a - 8'h01;
    case (base)
      `ARB_OFS_IN_CUR: res_index = 4'h0;
      `ARB_OFS_BT_CUR: res_index = 4'h1;
      `ARB_OFS_BUS_V:  res_index = 4'h2;
      `ARB_OFS_AD1_V:  res_index = 4'h3;
      `ARB_OFS_AD2_V:  res_index = 4'h4;
      `ARB_OFS_BAT_V:  res_index = 4'h5;
      `ARB_OFS_SYS_V:  res_index = 4'h6;
      `ARB_OFS_THERM:  res_index = 4'h7;
      `ARB_OFS_DIE_T:  res_index = 4'h8;
      default:         res_index = CH_NONE;
    endcase
  endfunction

  // disable bit of a channel in the two disable registers
  function automatic logic chan_off(input arb_pkg::arb_chan_t c,
                                    input logic [7:0] d0,
                                    input logic [7:0] d1);
    case (c)
      4'h0:    chan_off = d0[7];
      4'h1:    chan_off = d0[6];
      4'h2:    chan_off = d0[5];
      4'h3:    chan_off = d1[4];
      4'h4:    chan_off = d1[5];
      4'h5:    chan_off = d0[4];
      4'h6:    chan_off = d0[3];
      4'h7:    chan_off = d0[2];
      4'h8:    chan_off = d0[1];
      default: chan_off = 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // serial port
  // ----------------------------------------------------------------
  logic       start;
  logic       wb_vld;
  logic [7:0] wb_data;
  logic       rd_take;
  logic [7:0] rd_data;

  arb_i2c u_i2c (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_dev_addr  (DEV_ADDR),
    .i_scl       (i_scl),
    .i_sda       (i_sda),
    .o_sda_out   (o_sda_out),
    .o_sda_oe    (o_sda_oe),
    .o_start     (start),
    .o_wbyte_vld (wb_vld),
    .o_wbyte     (wb_data),
    .o_rd_take   (rd_take),
    .i_rd_byte   (rd_data)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]          ptr_q;
  logic                have_ptr_q;
  logic [7:0]          ctl_q;
  logic [7:0]          ctl_d;
  logic [7:0]          dis0_q;
  logic [7:0]          dis1_q;
  logic [7:0]          dschg_q;
  arb_pkg::arb_seq_t   seq_q;
  arb_pkg::arb_seq_t   seq_d;
  arb_pkg::arb_chan_t  chan_q;
  arb_pkg::arb_chan_t  chan_d;
  arb_pkg::arb_word_t  res_q [NUM_CH];
  arb_pkg::arb_word_t  shadow_q;
  arb_pkg::arb_chan_t  shadow_idx_q;
  logic                shadow_ok_q;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire host_wr  = wb_vld && have_ptr_q;
  wire wr_ctl   = host_wr && ptr_q == `ARB_OFS_CTRL;
  wire wr_dis0  = host_wr && ptr_q == `ARB_OFS_DIS0;
  wire wr_dis1  = host_wr && ptr_q == `ARB_OFS_DIS1;
  wire wr_dschg = host_wr && ptr_q == `ARB_OFS_DSCHG;
  wire conv_en  = ctl_q[`ARB_BIT_EN];
  wire one_shot = ctl_q[`ARB_BIT_RATE];
  wire pass_end = seq_q == arb_pkg::ARB_S_PICK && chan_q >= CH_END;
  wire ch_off   = chan_off(chan_q, dis0_q, dis1_q);
  wire store    = seq_q == arb_pkg::ARB_S_WAIT && conv_en && i_conv_done;

  always_comb begin
    ctl_d = ctl_q;
    if (i_wdog_expire) ctl_d[`ARB_BIT_EN] = 1'b0;
    if (pass_end && one_shot) ctl_d[`ARB_BIT_EN] = 1'b0;
    // a host write in the same cycle is the newer intent
    if (wr_ctl) ctl_d = wb_data;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_reg_rst) begin
      ctl_q   <= `ARB_RST_CTRL;
      dis0_q  <= 8'h00;
      dis1_q  <= 8'h00;
      dschg_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      if (wr_dis0) dis0_q <= wb_data & `ARB_MSK_DIS0;
      if (wr_dis1) dis1_q <= wb_data & `ARB_MSK_DIS1;
      if (wr_dschg) dschg_q[`ARB_BIT_DSCHG] <= wb_data[`ARB_BIT_DSCHG];
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_comb begin
    seq_d  = seq_q;
    chan_d = chan_q;
    case (seq_q)
      arb_pkg::ARB_S_IDLE: begin
        chan_d = 4'h0;
        if (conv_en) seq_d = arb_pkg::ARB_S_PICK;
      end
      arb_pkg::ARB_S_PICK: begin
        if (!conv_en) begin
          seq_d = arb_pkg::ARB_S_IDLE;
        end else if (pass_end) begin
          seq_d  = one_shot ? arb_pkg::ARB_S_IDLE : arb_pkg::ARB_S_PICK;
          chan_d = 4'h0;
        end else if (ch_off) begin
          chan_d = chan_q + 4'h1;
        end else begin
          seq_d = arb_pkg::ARB_S_WAIT;
        end
      end
      arb_pkg::ARB_S_WAIT: begin
        if (!conv_en) begin
          seq_d = arb_pkg::ARB_S_IDLE;
        end else if (i_conv_done) begin
          seq_d  = arb_pkg::ARB_S_PICK;
          chan_d = chan_q + 4'h1;
        end
      end
      default: seq_d = arb_pkg::ARB_S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      seq_q  <= arb_pkg::ARB_S_IDLE;
      chan_q <= 4'h0;
    end else begin
      seq_q  <= seq_d;
      chan_q <= chan_d;
    end
  end

  // request drops the cycle after enable goes away
  assign o_conv_req  = seq_q == arb_pkg::ARB_S_WAIT;
  assign o_conv_chan = chan_q;
  assign o_conv_busy = seq_q != arb_pkg::ARB_S_IDLE;

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  // discharge reads as zero unless sensing enabled
  wire clamp = chan_q == CH_BT_CUR && i_conv_data[15] && !dschg_q[`ARB_BIT_DSCHG];
  wire arb_pkg::arb_word_t new_val = clamp ? `ARB_RST_RES : i_conv_data;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_res
    // front end sign kept as delivered
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
        res_q[g] <= `ARB_RST_RES;
      end else if (store && chan_q == 4'(g)) begin
        res_q[g] <= new_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // result addresses decoded
  wire arb_pkg::arb_chan_t ridx = res_index(ptr_q);
  wire                     hit  = ridx != CH_NONE;
  wire                     is_lo = !ptr_q[0];
  wire arb_pkg::arb_word_t rres = hit ? res_q[ridx[3:0]] : `ARB_RST_RES;
  wire use_shd = shadow_ok_q && shadow_idx_q == ridx;
  wire [7:0] lo_byte = use_shd ? shadow_q[7:0] : rres[7:0];
  wire [7:0] res_byte = is_lo ? lo_byte : rres[15:8];

  always_comb begin
    if (hit)                          rd_data = res_byte;
    else if (ptr_q == `ARB_OFS_CTRL)  rd_data = ctl_q;
    else if (ptr_q == `ARB_OFS_DIS0)  rd_data = dis0_q;
    else if (ptr_q == `ARB_OFS_DIS1)  rd_data = dis1_q;
    else if (ptr_q == `ARB_OFS_DSCHG) rd_data = dschg_q;
    else                              rd_data = 8'h00;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ptr_q        <= 8'h00;
      have_ptr_q   <= 1'b0;
      shadow_q     <= `ARB_RST_RES;
      shadow_idx_q <= CH_NONE;
      shadow_ok_q  <= 1'b0;
    end else begin
      if (start) begin
        have_ptr_q  <= 1'b0;
        shadow_ok_q <= 1'b0;
      end else if (wb_vld) begin
        have_ptr_q <= 1'b1;
        ptr_q      <= have_ptr_q ? ptr_q + 8'h01 : wb_data;
      end else if (rd_take) begin
        ptr_q <= ptr_q + 8'h01;
        // high byte read freezes the word
        if (hit && !is_lo) begin
          shadow_q     <= rres;
          shadow_idx_q <= ridx;
          shadow_ok_q  <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_store(arb_pkg::arb_chan_t c);
    store && chan_q == c;
  endsequence

  sequence s_wdog_hit;
    (i_wdog_expire && !wr_ctl) ##1 !conv_en;
  endsequence

  sequence s_pass_end(logic m);
    pass_end && conv_en && one_shot == m && !wr_ctl && !i_wdog_expire;
  endsequence

  property p_in_cur_store;
    s_store(CH_IN_CUR) |=> res_q[0] == $past(i_conv_data);
  endproperty
  a_in_cur_store: assert property (p_in_cur_store) else $error("input current not stored");

  property p_charge_pos;
    (s_store(CH_BT_CUR) and !i_conv_data[15]) |=> res_q[1] == $past(i_conv_data);
  endproperty
  a_charge_pos: assert property (p_charge_pos) else $error("charge current not stored");

  property p_dschg_gate;
    (s_store(CH_BT_CUR) and i_conv_data[15])
      |=> res_q[1] == ($past(dschg_q[`ARB_BIT_DSCHG]) ? $past(i_conv_data) : `ARB_RST_RES);
  endproperty
  a_dschg_gate: assert property (p_dschg_gate) else $error("discharge gating wrong");

  property p_wdog_stop;
    s_wdog_hit |=> !o_conv_req && seq_q == arb_pkg::ARB_S_IDLE;
  endproperty
  a_wdog_stop: assert property (p_wdog_stop) else $error("watchdog did not stop");

  property p_one_shot;
    s_pass_end(1'b1) |=> !conv_en && seq_q == arb_pkg::ARB_S_IDLE;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("single pass did not end");

  property p_continuous;
    s_pass_end(1'b0) |=> conv_en && seq_q == arb_pkg::ARB_S_PICK && chan_q == 4'h0;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous did not wrap");

  property p_skip;
    (seq_q == arb_pkg::ARB_S_PICK && conv_en && !pass_end && ch_off)
      |-> !o_conv_req ##1 (chan_q == 4'($past(chan_q) + 4'h1) && !o_conv_req);
  endproperty
  a_skip: assert property (p_skip) else $error("disabled channel converted");

  property p_snapshot;
    (rd_take && hit && !is_lo && !start && !wb_vld)
      |=> shadow_ok_q && shadow_q == $past(rres) && shadow_idx_q == $past(ridx);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

  property p_reset_zero;
    disable iff (1'b0)
    i_sys_rst |=> res_q[0] == `ARB_RST_RES && res_q[2] == `ARB_RST_RES && res_q[8] == `ARB_RST_RES;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("results not zero at reset");
endmodule // arb_bank

// ---- bench/arb_host.sv ----
// two-wire controller model that reads and writes the result bank
module arb_host #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic i_core_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  // every level held four clocks, well above the single clock the target needs
  task automatic tick();
    repeat (4) @(negedge i_core_clk);
  endtask

  task automatic start();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
    tick();
  endtask

  // eight bits msb first, then the acknowledge slot; data moves only with clock low
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
    logic [8:0] s;
    logic [8:0] q;
    s = {w, last};
    q = 9'h000;
    for (int i = 8; i >= 0; i--) begin
      o_sda = s[i];
      tick();
      o_scl = 1'b1;
      tick();
      q = {q[7:0], i_sda};
      o_scl = 1'b0;
      tick();
    end
    r = q[8:1];
    ack = q[0];
  endtask

  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] b;
    logic       k;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, b, k);
    xfer(a, 1'b1, b, k);
    xfer(d, 1'b1, b, k);
    stop();
  endtask

  // one byte, or both bytes of a word when two is set, taken in one transfer, then a closing nack
  task automatic read(input logic [7:0] a, input logic two, output logic [15:0] v);
    logic [7:0] b;
    logic       k;
    v = 16'h0000;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, b, k);
    xfer(a, 1'b1, b, k);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, b, k);
    if (two) begin
      xfer(8'hff, 1'b0, b, k);
      v[15:8] = b;
    end
    xfer(8'hff, 1'b1, b, k);
    v[7:0] = b;
    stop();
  endtask
endmodule // arb_host

// ---- bench/arb_bank_bench.sv ----
// self-checking bench for the measurement result bank
module arb_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic               core_clk;
  logic               sys_rst;
  logic               reg_rst;
  logic               wdog_expire;
  logic               scl;
  logic               host_sda;
  logic               sda_oe;
  logic               conv_req;
  logic               conv_busy;
  logic               conv_done = 1'b0;
  logic               sda_out;
  logic [15:0]        rv;
  arb_pkg::arb_chan_t conv_chan;
  arb_pkg::arb_word_t conv_data = 16'h0000;
  arb_pkg::arb_word_t conv_val [0:8];
  wire logic          sda_line;
  int                 lat = 0;
  int                 dones = 0;
  int                 d0;
  int                 failures;
  int                 checked;

  // pulled-up data line, low when either party pulls it; target output is tied low, so it pulls the line low when enabled
  assign sda_line = host_sda & (~sda_oe | sda_out);

  arb_host #(.DEV_ADDR(7'h50)) host (
    .i_core_clk (core_clk),
    .i_sda      (sda_line),
    .o_scl      (scl),
    .o_sda      (host_sda)
  );

  arb_bank DUT (
    .i_core_clk    (core_clk),
    .i_sys_rst     (sys_rst),
    .i_reg_rst     (reg_rst),
    .i_wdog_expire (wdog_expire),
    .i_scl         (scl),
    .i_sda         (sda_line),
    .o_sda_out     (sda_out),
    .o_sda_oe      (sda_oe),
    .o_conv_req    (conv_req),
    .o_conv_chan   (conv_chan),
    .o_conv_busy   (conv_busy),
    .i_conv_done   (conv_done),
    .i_conv_data   (conv_data)
  );

  // ----------------------------------------
  // clock and converter stand-in
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // answers three clocks after a request, one-cycle done pulse
  always @(negedge core_clk) begin
    conv_done <= 1'b0;
    lat       <= (conv_req && !conv_done) ? lat + 1 : 0;
    if (conv_req && !conv_done && lat == 2) begin
      conv_done <= 1'b1;
      conv_data <= conv_val[conv_chan];
      lat       <= 0;
      dones     <= dones + 1;
    end
  end

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, input logic two, input logic [15:0] exp);
    logic [15:0] v;
    host.read(a, two, v);
    check(v, exp);
  endtask

  // one-shot pass; a hang shows up as busy still high
  task automatic run_pass();
    int n;
    host.write(8'h2e, 8'hf0);
    n = 0;
    while (conv_busy !== 1'b0 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    check({15'h0000, conv_busy}, 16'h0000);
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    sys_rst     = 1'b1;
    reg_rst     = 1'b0;
    wdog_expire = 1'b0;
    failures    = 0;
    checked     = 0;
    conv_val    = '{16'h1388, 16'h1f40, 16'h7530, 16'h7530, 16'h2710, 16'h4e20, 16'h5dc0, 16'h03ff, 16'h012c};
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 9; i++) rd(8'h31 + 8'(2 * i), 1'b1, 16'h0000);
    rd(8'h2e, 1'b0, 16'h0030);
    run_pass();
    for (int i = 0; i < 9; i++) rd(8'h31 + 8'(2 * i), 1'b1, conv_val[i]);
    rd(8'h2e, 1'b0, 16'h0070);
    rd(8'h32, 1'b0, 16'h0088);
    rd(8'h50, 1'b0, 16'h0000);
    host.write(8'h31, 8'haa);
    rd(8'h31, 1'b1, 16'h1388);
    // readings below zero
    conv_val[0] = 16'hff38;
    conv_val[1] = 16'hfc18;
    conv_val[8] = 16'hffb0;
    run_pass();
    rd(8'h31, 1'b1, 16'hff38);
    rd(8'h33, 1'b1, 16'h0000);
    rd(8'h41, 1'b1, 16'hffb0);
    host.write(8'h14, 8'h20);
    run_pass();
    rd(8'h33, 1'b1, 16'hfc18);
    // skipped channels keep their last result
    host.write(8'h2f, 8'h80);
    host.write(8'h30, 8'h10);
    conv_val[0] = 16'h0064;
    conv_val[2] = 16'h1234;
    conv_val[3] = 16'h0bb8;
    run_pass();
    rd(8'h31, 1'b1, 16'hff38);
    rd(8'h37, 1'b1, 16'h7530);
    rd(8'h35, 1'b1, 16'h1234);
    // continuous conversion stopped by the watchdog
    d0 = dones;
    host.write(8'h2e, 8'h80);
    for (int n = 0; n < 1000 && dones - d0 < 12; n++) @(negedge core_clk);
    check((dones - d0 >= 12) ? 16'h0001 : 16'h0000, 16'h0001);
    // result moves between its two bytes; the word must still come from one conversion
    fork
      host.read(8'h3b, 1'b1, rv);
      begin
        repeat (380) @(negedge core_clk);
        conv_val[5] = 16'h2222;
      end
    join
    check(rv, 16'h4e20);
    wdog_expire = 1'b1;
    @(negedge core_clk);
    wdog_expire = 1'b0;
    repeat (8) @(negedge core_clk);
    check({15'h0000, conv_busy}, 16'h0000);
    rd(8'h2e, 1'b0, 16'h0000);
    reg_rst = 1'b1;
    @(negedge core_clk);
    reg_rst = 1'b0;
    rd(8'h2e, 1'b0, 16'h0030);
    rd(8'h2f, 1'b0, 16'h0000);
    rd(8'h30, 1'b0, 16'h0000);
    rd(8'h14, 1'b0, 16'h0000);
    finish_test();
  end

  // run budget is about two fifths of this span
  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    finish_test();
  end
endmodule // arb_bank_bench
